// ===== hw/ppp_defs.svh
// constants for the parallel program port: command codes, addresses, sizes
// assumes inclusion by bare name from the package
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH
`define PPP_CMD_ERASE 12'h010
`define PPP_CMD_RD_ID 12'h001
`define PPP_CMD_RD_XCFG 12'h002
`define PPP_CMD_PG_XCFG_LG 12'h003
`define PPP_CMD_PG_XCFG_SM 12'h020
`define PPP_CMD_RD_DATA 12'h004
`define PPP_CMD_PG_DATA 12'hFFE
`define PPP_CFG_ADDR_SM 13'h0FFF
`define PPP_CFG_ADDR_LG 13'h1FFF
`define PPP_TOP_ADDR_SM 13'h07FF
`define PPP_TOP_ADDR_LG 13'h0FFF
`define PPP_ERASED_WORD 12'hFFF
`define PPP_MEM_WORDS 4096
`define PPP_ID_WORD_SM 12'h5A1
`define PPP_ID_WORD_LG 12'h5A2
`endif

// ===== hw/ppp_pkg.sv
// types shared by both ends of the parallel program port
// assumes ppp_defs.svh on the include path
package ppp_pkg;
`include "ppp_defs.svh"
	typedef logic [11:0] word_t;
	typedef logic [12:0] addr_t;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ERASE,
		OP_RD_ID,
		OP_RD_XCFG,
		OP_PG_XCFG,
		OP_RD_DATA,
		OP_PG_DATA
	} op_t;
endpackage

// ===== hw/ppp_if.sv
// pin bundle between the programmer and the device
// data pins are two-way; the interface resolves level from the enables
`timescale 1ns/1ps
interface ppp_if;
	logic master_clear_pin;
	logic program_strobe_pin;
	logic address_step_pin;
	logic [3:0] low_nibble_prog;
	logic [7:0] high_byte_prog;
	logic data_oe_prog;
	logic [3:0] low_nibble_dev;
	logic [7:0] high_byte_dev;
	logic data_oe_dev;
	logic [3:0] low_nibble_port;
	logic [7:0] high_byte_port;
	// nobody driving: pins show the inverse of the last programmer word, so a stale word never passes as an answer
	assign low_nibble_port = data_oe_dev ? low_nibble_dev : (data_oe_prog ? low_nibble_prog : ~low_nibble_prog);
	assign high_byte_port = data_oe_dev ? high_byte_dev : (data_oe_prog ? high_byte_prog : ~high_byte_prog);
	modport device (
		input master_clear_pin,
		input program_strobe_pin,
		input address_step_pin,
		input low_nibble_port,
		input high_byte_port,
		output low_nibble_dev,
		output high_byte_dev,
		output data_oe_dev
	);
	modport programmer (
		output master_clear_pin,
		output program_strobe_pin,
		output address_step_pin,
		output low_nibble_prog,
		output high_byte_prog,
		output data_oe_prog,
		input low_nibble_port,
		input high_byte_port
	);
endinterface

// ===== hw/ppp_programmer.sv
// programmer end: turns user requests into pin sequences
// assumes clk_i at 250 MHz; one request at a time, req_i taken when ready_o
`timescale 1ns/1ps
module ppp_programmer
	import ppp_pkg::*;
#(
	parameter int unsigned PHASE_CYC = 16,
	parameter int unsigned WAIT_CYC = 5000000
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic req_i,
	input wire logic [2:0] kind_i,
	input wire logic [11:0] cmd_i,
	input wire logic [11:0] wdata_i,
	output logic ready_o,
	output logic rvalid_o,
	output logic [11:0] rdata_o,
	ppp_if.programmer pins
);
	// kind_i: 0 enter (master_clear_pin cycle + command), 1 step, 2 write, 3 readback, 4 exit
	typedef enum {S_IDLE, S_SETUP, S_RISE, S_WAIT, S_LOW, S_HIGH} pst_t;
	pst_t state_reg;
	logic [31:0] cnt_reg;
	logic [2:0] kind_reg;
	logic [11:0] data_reg;
	logic master_clear_pin_reg, strobe_reg, step_reg, oe_reg;
	logic [11:0] pin_s1, pin_s2, pin_s3, pin_word;

	// port pins come from the link clock domain; a word counts once two stages agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_word <= '0;
		end else begin
			pin_s1 <= {pins.high_byte_port, pins.low_nibble_port}; // RULE_21
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s3 == pin_s2) pin_word <= pin_s3;
		end
	end
	assign ready_o = state_reg == S_IDLE;
	assign pins.master_clear_pin = master_clear_pin_reg;
	assign pins.program_strobe_pin = strobe_reg;
	assign pins.address_step_pin = step_reg;
	assign pins.data_oe_prog = oe_reg;
	assign pins.low_nibble_prog = data_reg[3:0]; // RULE_21
	assign pins.high_byte_prog = data_reg[11:4];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= S_IDLE;
			cnt_reg <= '0;
			kind_reg <= '0;
			data_reg <= '0;
			master_clear_pin_reg <= 1'b0;
			strobe_reg <= 1'b1;
			step_reg <= 1'b0;
			oe_reg <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= '0;
		end else begin
			rvalid_o <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (req_i) begin
						kind_reg <= kind_i;
						cnt_reg <= PHASE_CYC;
						if (kind_i == 3'd0) begin
							master_clear_pin_reg <= 1'b0; // RULE_22 RULE_23
							strobe_reg <= 1'b1; // RULE_10
							data_reg <= cmd_i; // RULE_01
							oe_reg <= 1'b0; // first phase released: device may still drive after a read
							state_reg <= S_SETUP;
						end else if (kind_i == 3'd4) begin
							strobe_reg <= 1'b0; // RULE_10
							state_reg <= S_HIGH;
						end else if (kind_i == 3'd2) begin
							data_reg <= wdata_i; // RULE_16
							oe_reg <= 1'b1;
							state_reg <= S_SETUP;
						end else begin
							oe_reg <= 1'b0;
							state_reg <= S_SETUP;
						end
					end
				end
				S_SETUP: begin
					if (cnt_reg == 0) begin
						cnt_reg <= PHASE_CYC;
						if (kind_reg == 3'd0 && !oe_reg) begin
							oe_reg <= 1'b1;
						end else if (kind_reg == 3'd0) begin
							master_clear_pin_reg <= 1'b1;
							state_reg <= S_RISE;
						end else begin
							if (kind_reg == 3'd1) step_reg <= 1'b1; // RULE_17 RULE_18
							else strobe_reg <= 1'b0; // RULE_14 RULE_19
							state_reg <= S_LOW;
						end
					end else cnt_reg <= cnt_reg - 1;
				end
				S_RISE: begin
					if (cnt_reg == 0) begin
						oe_reg <= 1'b0;
						cnt_reg <= WAIT_CYC; // RULE_11
						state_reg <= S_WAIT;
					end else cnt_reg <= cnt_reg - 1;
				end
				S_WAIT: begin
					if (cnt_reg == 0) state_reg <= S_IDLE;
					else cnt_reg <= cnt_reg - 1;
				end
				S_LOW: begin
					if (cnt_reg == 0) begin
						if (kind_reg == 3'd3) begin
							rdata_o <= pin_word; // RULE_15
							rvalid_o <= 1'b1;
						end
						step_reg <= 1'b0;
						strobe_reg <= 1'b1;
						cnt_reg <= PHASE_CYC;
						state_reg <= S_HIGH;
					end else cnt_reg <= cnt_reg - 1;
				end
				default: begin
					if (cnt_reg == 0) begin
						if (kind_reg == 3'd4) begin
							master_clear_pin_reg <= 1'b0; // RULE_10
							strobe_reg <= 1'b1;
						end
						if (kind_reg == 3'd1) begin
							rdata_o <= pin_word;
							rvalid_o <= 1'b1;
						end
						oe_reg <= 1'b0;
						state_reg <= S_IDLE;
					end else cnt_reg <= cnt_reg - 1;
				end
			endcase
		end
	end
endmodule

// ===== hw/ppp_device.sv
// device end: command latch, address pointer, program memory and config words
// runs on link_clk_i; all pins pass a three-stage synchroniser
`timescale 1ns/1ps
`include "ppp_defs.svh"
// Summary of operation
// [RULE_01] latch 12-bit command from both ports
// [RULE_02] code 010h erases all program memory
// [RULE_03] 001h reads identity, 002h extended config
// [RULE_04] 003h or 020h programs extended config
// [RULE_05] code 004h enters sequential read
// [RULE_06] code FFEh enters sequential program
// [RULE_07] reserved codes perform no operation
// [RULE_08] erase clears memory and both config words
// [RULE_09] erase active until strobe falls
// [RULE_10] programmer drops strobe then master clear
// [RULE_11] programmer waits before first step pulse
// [RULE_12] second step releases reset, address config
// [RULE_13] later steps advance, wrap, drive word
// [RULE_14] first strobe at address writes word
// [RULE_15] second strobe reads word back
// [RULE_16] programmer places data before strobe
// [RULE_17] steps without strobe skip locations
// [RULE_18] config words only via own commands
// [RULE_19] programmer holds strobe minimum time
// [RULE_20] programmer saves extended config before erase
// [RULE_21] low nibble bits 3:0, high byte 11:4
// [RULE_22] command latched at master clear rise
// [RULE_23] new command by master clear recycle
// [RULE_24] edges only; steps ignored while strobe low
module ppp_device
	import ppp_pkg::*;
#(
	parameter bit LARGE = 1'b1
) (
	input wire logic link_clk_i,
	input wire logic srst_i,
	output logic erase_active_o,
	output logic in_reset_o,
	output logic [12:0] address_o,
	ppp_if.device pins
);
	import ppp_pkg::*;

	logic [2:0] master_clear_pin_sync, strobe_sync, step_sync;
	logic [11:0] data_s1, data_s2, data_s3, data_reg;
	logic master_clear_pin_reg, strobe_reg, step_reg;
	logic master_clear_pin_rise, strobe_fall, strobe_rise, step_rise;
	op_t op_reg, op_next;
	logic [1:0] step_cnt_reg;
	logic [1:0] strobe_cnt_reg;
	addr_t addr_reg;
	word_t mem_reg [`PPP_MEM_WORDS];
	word_t cfg_reg, xcfg_reg, out_reg, rd_word;
	logic oe_reg;
	addr_t cfg_addr, top_addr;
	logic [11:0] id_word;

	assign cfg_addr = LARGE ? `PPP_CFG_ADDR_LG : `PPP_CFG_ADDR_SM;
	assign top_addr = LARGE ? `PPP_TOP_ADDR_LG : `PPP_TOP_ADDR_SM;
	// identity value arbitrary
	assign id_word = LARGE ? `PPP_ID_WORD_LG : `PPP_ID_WORD_SM;

	// only stage 2/3 are compared, stage 1 feeds stage 2 alone
	always_ff @(posedge link_clk_i) begin
		if (srst_i) begin
			master_clear_pin_sync <= '0;
			strobe_sync <= 3'b111;
			step_sync <= '0;
			data_s1 <= '0;
			data_s2 <= '0;
			data_s3 <= '0;
			data_reg <= '0;
		end else begin
			master_clear_pin_sync <= {master_clear_pin_sync[1:0], pins.master_clear_pin};
			strobe_sync <= {strobe_sync[1:0], pins.program_strobe_pin};
			step_sync <= {step_sync[1:0], pins.address_step_pin};
			data_s1 <= {pins.high_byte_port, pins.low_nibble_port}; // RULE_21
			data_s2 <= data_s1;
			data_s3 <= data_s2;
			if (data_s3 == data_s2) data_reg <= data_s3;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (srst_i) begin
			master_clear_pin_reg <= 1'b0;
			strobe_reg <= 1'b1;
			step_reg <= 1'b0;
		end else begin
			if (master_clear_pin_sync[2] == master_clear_pin_sync[1]) master_clear_pin_reg <= master_clear_pin_sync[2];
			if (strobe_sync[2] == strobe_sync[1]) strobe_reg <= strobe_sync[2];
			if (step_sync[2] == step_sync[1]) step_reg <= step_sync[2];
		end
	end

	assign master_clear_pin_rise = !master_clear_pin_reg && master_clear_pin_sync[2] && master_clear_pin_sync[1];
	assign strobe_fall = strobe_reg && !strobe_sync[2] && !strobe_sync[1]; // RULE_24
	assign strobe_rise = !strobe_reg && strobe_sync[2] && strobe_sync[1];
	assign step_rise = !step_reg && step_sync[2] && step_sync[1] && strobe_reg; // RULE_24

	always_comb begin
		case (data_reg) // RULE_01
			`PPP_CMD_ERASE: op_next = OP_ERASE; // RULE_02
			`PPP_CMD_RD_ID: op_next = OP_RD_ID; // RULE_03
			`PPP_CMD_RD_XCFG: op_next = OP_RD_XCFG;
			`PPP_CMD_PG_XCFG_LG: op_next = LARGE ? OP_PG_XCFG : OP_NONE; // RULE_04
			`PPP_CMD_PG_XCFG_SM: op_next = LARGE ? OP_NONE : OP_PG_XCFG;
			`PPP_CMD_RD_DATA: op_next = OP_RD_DATA; // RULE_05
			`PPP_CMD_PG_DATA: op_next = OP_PG_DATA; // RULE_06
			default: op_next = OP_NONE; // RULE_07
		endcase
	end

	always_ff @(posedge link_clk_i) begin
		if (srst_i || !master_clear_pin_reg && !master_clear_pin_sync[2]) begin
			op_reg <= OP_NONE;
		end else if (master_clear_pin_rise) begin
			op_reg <= op_next; // RULE_22 RULE_23
		end
	end

	// erase held until strobe falls or master clear goes low
	always_ff @(posedge link_clk_i) begin
		if (srst_i) begin
			erase_active_o <= 1'b0;
		end else if (master_clear_pin_rise && op_next == OP_ERASE) begin
			erase_active_o <= 1'b1; // RULE_09
		end else if (strobe_fall || !master_clear_pin_reg) begin
			erase_active_o <= 1'b0;
		end
	end

	// saturates at two: the first step only counts, the second leaves reset and loads the config address
	always_ff @(posedge link_clk_i) begin
		if (srst_i || master_clear_pin_rise) begin
			step_cnt_reg <= '0;
		end else if (step_rise && step_cnt_reg < 2'd2) begin
			step_cnt_reg <= step_cnt_reg + 2'd1;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (srst_i || master_clear_pin_rise) begin
			in_reset_o <= 1'b1;
		end else if (step_rise && step_cnt_reg == 2'd1) begin
			in_reset_o <= 1'b0; // RULE_12
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (srst_i || master_clear_pin_rise) begin
			addr_reg <= '0;
		end else if (step_rise && step_cnt_reg == 2'd1) begin
			addr_reg <= cfg_addr; // RULE_12
		end else if (step_rise && step_cnt_reg == 2'd2) begin
			if (addr_reg == cfg_addr || addr_reg == top_addr) addr_reg <= '0; // RULE_13
			else addr_reg <= addr_reg + 13'd1; // RULE_17
		end
	end

	// a step opens a fresh address, so the write and read-back count starts over
	always_ff @(posedge link_clk_i) begin
		if (srst_i || master_clear_pin_rise || step_rise) begin
			strobe_cnt_reg <= '0;
		end else if (strobe_rise && !in_reset_o && strobe_cnt_reg < 2'd2) begin
			strobe_cnt_reg <= strobe_cnt_reg + 2'd1;
		end
	end
	assign address_o = addr_reg;

	// storage: writes only clear bits, erase sets all to ones
	always_ff @(posedge link_clk_i) begin
		if (srst_i || erase_active_o) begin
			for (int i = 0; i < `PPP_MEM_WORDS; i++) mem_reg[i] <= `PPP_ERASED_WORD; // RULE_08
			cfg_reg <= `PPP_ERASED_WORD;
			xcfg_reg <= `PPP_ERASED_WORD;
		end else if (strobe_fall && !in_reset_o && strobe_cnt_reg == 2'd0) begin // RULE_14
			if (op_reg == OP_PG_DATA) begin
				if (addr_reg == cfg_addr) cfg_reg <= cfg_reg & data_reg;
				else mem_reg[addr_reg[11:0]] <= mem_reg[addr_reg[11:0]] & data_reg;
			end else if (op_reg == OP_PG_XCFG) begin
				xcfg_reg <= xcfg_reg & data_reg; // RULE_18
			end
		end
	end

	always_comb begin
		if (op_reg == OP_RD_ID) rd_word = id_word;
		else if (op_reg == OP_RD_XCFG || op_reg == OP_PG_XCFG) rd_word = xcfg_reg;
		else if (addr_reg == cfg_addr) rd_word = cfg_reg;
		else rd_word = mem_reg[addr_reg[11:0]];
	end

	// drive ports in read ops, and in program ops during the read-back strobe
	always_ff @(posedge link_clk_i) begin
		if (srst_i) begin
			oe_reg <= 1'b0;
			out_reg <= '0;
		end else begin
			out_reg <= rd_word;
			if (in_reset_o || !master_clear_pin_reg) oe_reg <= 1'b0;
			else if (op_reg == OP_RD_DATA || op_reg == OP_RD_ID || op_reg == OP_RD_XCFG) oe_reg <= 1'b1; // RULE_12 RULE_13
			else if (op_reg == OP_PG_DATA || op_reg == OP_PG_XCFG)
				oe_reg <= strobe_cnt_reg == 2'd1 && !strobe_reg; // RULE_15
			else oe_reg <= 1'b0;
		end
	end
	assign pins.data_oe_dev = oe_reg;
	assign pins.low_nibble_dev = out_reg[3:0];
	assign pins.high_byte_dev = out_reg[11:4];
endmodule

// ===== testbench/ppp_checker_sva.sv
// pin-level checks between the programmer and the device ends
// assumes the interface pins sampled on the link clock
`timescale 1ns/1ps
module ppp_checker (
	input wire logic link_clk_i,
	input wire logic srst_i,
	input wire logic master_clear_pin,
	input wire logic program_strobe_pin,
	input wire logic address_step_pin,
	input wire logic [3:0] low_nibble_prog,
	input wire logic [7:0] high_byte_prog,
	input wire logic data_oe_prog,
	input wire logic [3:0] low_nibble_port,
	input wire logic [7:0] high_byte_port,
	input wire logic data_oe_dev
);
	default clocking cb @(posedge link_clk_i);
	endclocking
	default disable iff (srst_i);
	chk_cmd_held: assert property (
		$rose(master_clear_pin) |-> (data_oe_prog && $stable({high_byte_port, low_nibble_port}))[*2])
		else $error("command not held at master clear rise");
	chk_erase_strobe: assert property (
		$rose(master_clear_pin) && {high_byte_port, low_nibble_port} == 12'h010 |-> program_strobe_pin)
		else $error("erase entered with strobe low");
	chk_write_stable: assert property (
		!program_strobe_pin && data_oe_prog |-> $stable({high_byte_prog, low_nibble_prog}))
		else $error("write data moved under strobe");
	chk_no_clash: assert property (
		!(data_oe_dev && data_oe_prog))
		else $error("both ends drive the data pins");
	chk_step_strobe: assert property (
		$rose(address_step_pin) |-> program_strobe_pin && master_clear_pin)
		else $error("step outside mode or under strobe");
	chk_step_width: assert property (
		$rose(address_step_pin) |=> address_step_pin)
		else $error("step pulse too short");
	chk_dev_drive_mode: assert property (
		$rose(data_oe_dev) |-> master_clear_pin)
		else $error("device drives outside mode");
	chk_dev_release: assert property (
		!master_clear_pin [*8] |-> !data_oe_dev)
		else $error("device still drives after master clear low");
	cov_enter: cover property ($rose(master_clear_pin));
	cov_dev_drive: cover property ($rose(data_oe_dev));
	cov_write: cover property ($fell(program_strobe_pin) && data_oe_prog);
endmodule

// ===== testbench/parallel_program_port_tb.sv
// self-checking bench: programmer end wired pin to pin to the device end
// assumes package, interface and both ends compiled first
`timescale 1ns/1ps
`include "ppp_defs.svh"
module parallel_program_port_tb;
	import ppp_pkg::*;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_i = 1'b0;
	logic [2:0] kind_i = 3'h0;
	logic [11:0] cmd_i = 12'h000;
	logic ready, rvalid, erase_active, in_reset;
	logic [11:0] rdata;
	logic [12:0] dev_addr;
	word_t got;
	int errors = 0;
	int tests_run = 0;
	always #2 clk_i = ~clk_i;
	always #16 link_clk_i = ~link_clk_i;
	ppp_if i_ppp_if();
	ppp_programmer #(.PHASE_CYC(64), .WAIT_CYC(50)) i_ppp_programmer (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i),
		.kind_i(kind_i), .cmd_i(cmd_i), .wdata_i(cmd_i), .ready_o(ready), .rvalid_o(rvalid), .rdata_o(rdata),
		.pins(i_ppp_if.programmer));
	ppp_device #(.LARGE(1'b1)) i_ppp_device (.link_clk_i(link_clk_i), .srst_i(srst_i), .erase_active_o(erase_active),
		.in_reset_o(in_reset), .address_o(dev_addr), .pins(i_ppp_if.device));
	ppp_checker i_ppp_checker (.link_clk_i(link_clk_i), .srst_i(srst_i),
		.master_clear_pin(i_ppp_if.master_clear_pin), .program_strobe_pin(i_ppp_if.program_strobe_pin),
		.address_step_pin(i_ppp_if.address_step_pin), .low_nibble_prog(i_ppp_if.low_nibble_prog),
		.high_byte_prog(i_ppp_if.high_byte_prog), .data_oe_prog(i_ppp_if.data_oe_prog),
		.low_nibble_port(i_ppp_if.low_nibble_port), .high_byte_port(i_ppp_if.high_byte_port),
		.data_oe_dev(i_ppp_if.data_oe_dev));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// one request; the same word serves as command and write data
	task automatic op(input logic [2:0] k, input logic [11:0] c);
		int n;
		n = 0;
		got = 12'hXXX;
		req_i <= 1'b1;
		kind_i <= k;
		cmd_i <= c;
		@(posedge clk_i);
		req_i <= 1'b0;
		do begin
			@(posedge clk_i);
			if (rvalid) got = rdata;
			n++;
		end while (!ready && n < 2000);
		if (!ready) begin
			errors++;
			complete_run();
		end
	endtask
	task automatic enter(input logic [11:0] c);
		op(3'h0, c);
		op(3'h1, 12'h000);
		op(3'h1, 12'h000);
	endtask
	task automatic leave(input string name);
		op(3'h4, 12'h000);
		$display("test %s done, mismatches %0d", name, errors);
	endtask
	task automatic t_erase();
		word_t saved;
		enter(`PPP_CMD_RD_XCFG);
		saved = got;
		op(3'h4, 12'h000);
		op(3'h0, `PPP_CMD_ERASE);
		check(erase_active, 1'b1);
		op(3'h4, 12'h000);
		check(erase_active, 1'b0);
		enter(`PPP_CMD_RD_XCFG);
		check(got, `PPP_ERASED_WORD);
		op(3'h4, 12'h000);
		enter(`PPP_CMD_RD_DATA);
		check(got, `PPP_ERASED_WORD);
		op(3'h1, 12'h000);
		check(got, `PPP_ERASED_WORD);
		op(3'h4, 12'h000);
		enter(`PPP_CMD_PG_XCFG_LG);
		op(3'h2, saved);
		op(3'h3, 12'h000);
		check(got, saved);
		leave("erase");
	endtask
	task automatic t_config();
		enter(`PPP_CMD_RD_ID);
		check(got, `PPP_ID_WORD_LG);
		op(3'h4, 12'h000);
		// small-variant code must be ignored on the large variant
		enter(`PPP_CMD_PG_XCFG_SM);
		op(3'h2, 12'h000);
		op(3'h4, 12'h000);
		enter(`PPP_CMD_PG_XCFG_LG);
		op(3'h2, 12'h0F0);
		op(3'h3, 12'h000);
		check(got, 12'h0F0);
		op(3'h4, 12'h000);
		enter(`PPP_CMD_RD_XCFG);
		check(got, 12'h0F0);
		leave("config");
	endtask
	task automatic t_program();
		enter(`PPP_CMD_PG_DATA);
		check(in_reset, 1'b0);
		check(dev_addr, `PPP_CFG_ADDR_LG);
		op(3'h2, 12'hA5C);
		op(3'h3, 12'h000);
		check(got, 12'hA5C);
		op(3'h1, 12'h000);
		check(dev_addr, 13'h0000);
		op(3'h2, 12'h3C3);
		op(3'h3, 12'h000);
		check(got, 12'h3C3);
		op(3'h2, 12'h000);
		op(3'h1, 12'h000);
		op(3'h1, 12'h000);
		check(dev_addr, 13'h0002);
		leave("program");
	endtask
	task automatic t_reserved();
		enter(12'h055);
		op(3'h2, 12'h000);
		check(erase_active, 1'b0);
		check(i_ppp_if.data_oe_dev, 1'b0);
		leave("reserved");
	endtask
	task automatic t_read();
		enter(`PPP_CMD_RD_DATA);
		check(got, 12'hA5C);
		op(3'h1, 12'h000);
		check(got, 12'h3C3);
		op(3'h1, 12'h000);
		check(got, `PPP_ERASED_WORD);
		check(dev_addr, 13'h0001);
		leave("read");
	endtask
	initial begin
		repeat (8) @(posedge link_clk_i);
		@(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_erase();
		t_config();
		t_program();
		t_reserved();
		t_read();
		t_erase();
		complete_run();
	end
	// about 80 requests of at most some 300 cycles each fit well inside this
	initial begin
		#250000;
		errors++;
		complete_run();
	end
endmodule
